// File: src/pcstk_pkg.sv
// Purpose: shared constants and types for the program counter and return stack
// Assumes: one system clock, one sequencer event per cycle
// Notes:   apb offsets below are byte addresses, one word per register
package pcstk_pkg;
  // stack index
  localparam int          IDX_W        = 4;
  localparam logic [3:0]  IDX_RESET    = 4'h5;
  localparam logic [2:0]  IDX_HANG     = 3'h6;
  localparam logic [2:0]  IDX_DEPTH    = 3'h5;
  localparam int          RAS_DEPTH    = 5;
  // interrupt context stack
  localparam int          ICS_DEPTH    = 3;
  localparam logic [1:0]  ICS_FREE_RST = 2'h3;
  // instruction address
  localparam logic [12:0] ADDR_RESET   = 13'h0000;
  localparam int          CALL_IMM_W   = 11;
  // apb map
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STATE    = 8'h04;
  localparam logic [7:0]  OFS_ADDR     = 8'h08;
  localparam logic [7:0]  OFS_EVT_STAT = 8'h0C;
  localparam logic [7:0]  OFS_EVT_CLR  = 8'h10;
  localparam logic [7:0]  OFS_EVT_EN   = 8'h14;
  localparam logic [0:0]  CTRL_RESET   = 1'h1;
  localparam int          CTRL_RUN_BIT = 0;
  // state register fields
  localparam int          ST_IDX_LSB   = 0;
  localparam int          ST_FREE_LSB  = 4;
  localparam int          ST_HANG_BIT  = 8;
  localparam int          ST_PIN_BIT   = 9;
  // event bits
  localparam int          EVT_W        = 4;
  localparam int          EVT_OVF      = 0;
  localparam int          EVT_UDF      = 1;
  localparam int          EVT_DROP     = 2;
  localparam int          EVT_TBLERR   = 3;
  localparam logic [3:0]  EVT_RESET    = 4'h0;

  // sequencer events, at most one set per cycle
  typedef struct packed {
    logic step;        // plain advance
    logic call_imm;    // call, immediate target
    logic call_ar;     // call via address_reg
    logic jump_dir;    // direct_branch
    logic jump_ar;     // indirect_branch
    logic tbl_first;   // table_read cycle 1
    logic tbl_second;  // table_read cycle 2
    logic push_ar;     // push address_reg
    logic pop_ar;      // pop into address_reg
    logic ret;         // plain return
    logic ret_skip;    // return_and_skip
    logic irq_acc;     // interrupt accepted
    logic irq_ret;     // irq_return
  } seq_ev_t;

  typedef enum logic [1:0] {
    TBL_IDLE = 2'b01,
    TBL_WAIT = 2'b10
  } tbl_state_t;
endpackage

// File: src/pcstk_core.sv
// Purpose: program counter, return stack and interrupt context stack
// Assumes: sequencer on sys_clk, apb slave with zero wait states
// Notes:   hang-up pin is open drain, pulled low on stack overrun
// Contract
// - address counter is binary, 11, 12 or 13 bits per variant
// - reset loads address counter with zero
// - instruction space runs from zero to the variant top address
// - immediate call targets only zero to 07FFH
// - branches, indirect call and table read reach the whole space
// - stack index is 4 bits with top bit always zero
// - five return entries as wide as the address counter
// - entry written on call, table read cycle 1, interrupt accept
// - push of address_reg stores it at the indexed entry
// - hang-up output low while stack index is 6 or more
// - interrupt accept saves bank and flags into three-entry stack
// - irq_return restores context, increments index and free count
// - over three nested interrupts, newest saved, oldest dropped
// - calls, table cycle 1, push: index -1, free count unchanged
// - interrupt accept decrements index and free count
// - returns, table cycle 2, pop: index +1, free count unchanged
// - hang-up is open drain active low, meant for chip reset
`timescale 1ns/10ps
`default_nettype none
module pcstk_core
  import pcstk_pkg::*;
#(
  parameter int ADDR_W = 11,        // 11, 12 or 13
  parameter int ROM_TOP = 32'h7FF,  // last instruction word
  parameter int CTX_W = 5           // 5 or 6
) (
  input  wire logic              sys_clk,         // 250 MHz
  input  wire logic              srst,            // sync reset, high
  input  wire logic [7:0]        paddr,           // apb address
  input  wire logic              psel,            // apb select
  input  wire logic              penable,         // apb access phase
  input  wire logic              pwrite,          // apb direction
  input  wire logic [31:0]       pwdata,          // apb write data
  output logic [31:0]            prdata,          // apb read data
  output logic                   pready,          // apb ready
  output logic                   pslverr,         // apb error
  output logic                   irq,             // level interrupt
  input  wire seq_ev_t           seq_ev,          // sequencer events
  input  wire logic [ADDR_W-1:0] branch_target,   // immediate target
  input  wire logic [ADDR_W-1:0] irq_vector,      // vector address
  input  wire logic [ADDR_W-1:0] address_reg,     // address register
  input  wire logic [CTX_W-1:0]  status_ctx_in,   // bank and flags
  output logic [ADDR_W-1:0]      instr_addr,      // rom address
  output logic [ADDR_W-1:0]      address_pop,     // popped word
  output logic [CTX_W-1:0]       status_ctx_out,  // restored context
  output logic                   ctx_restore,     // restore pulse
  input  wire logic              hangup_in,       // pin level
  output logic                   hangup_out_n,    // pin drive value
  output logic                   hangup_oe_n      // low while pulling
);

  // elaboration checks
  if (!(ADDR_W inside {11, 12, 13}))
    $error("ADDR_W must be 11, 12 or 13");
  if (ROM_TOP >= (1 << ADDR_W) || ROM_TOP < 32'h7FF)
    $error("ROM_TOP outside address range");
  if (!(CTX_W inside {5, 6}))
    $error("CTX_W must be 5 or 6");

  localparam logic [ADDR_W-1:0] TOP = ADDR_W'(ROM_TOP);

  // push or pop detection, used by index and events
  function automatic logic is_push(input seq_ev_t e);
    return e.call_imm | e.call_ar | e.tbl_first | e.push_ar | e.irq_acc;
  endfunction
  function automatic logic is_pop(input seq_ev_t e);
    return e.ret | e.ret_skip | e.tbl_second | e.pop_ar | e.irq_ret;
  endfunction

  // state
  logic [ADDR_W-1:0] instr_addr_counter_reg;
  logic [ADDR_W-1:0] instr_addr_counter_next;
  logic [IDX_W-1:0]  stack_index_reg;
  logic [IDX_W-1:0]  stack_index_next;
  logic [1:0]        ics_free_reg;
  logic [1:0]        ics_free_next;
  logic [ADDR_W-1:0] return_addr_stack [RAS_DEPTH];
  logic [CTX_W-1:0]  irq_context_stack [ICS_DEPTH];
  tbl_state_t        tbl_reg;
  tbl_state_t        tbl_next;
  logic [0:0]        ctrl_reg;
  logic [EVT_W-1:0]  evt_stat_reg;
  logic [EVT_W-1:0]  evt_en_reg;
  logic [EVT_W-1:0]  evt_set;
  logic [ADDR_W-1:0] address_pop_reg;
  logic [CTX_W-1:0]  ctx_out_reg;
  logic              ctx_restore_reg;
  logic              pin_meta_reg;
  logic              pin_sync_reg;

  // decode
  wire               any_push = is_push(seq_ev);
  wire               any_pop  = is_pop(seq_ev);
  wire [2:0]         idx_lo   = stack_index_reg[2:0];
  wire [2:0]         idx_dec  = idx_lo - 3'h1;
  wire [2:0]         idx_inc  = idx_lo + 3'h1;
  wire               hang     = (idx_lo >= IDX_HANG);
  wire               rd_valid = (idx_lo < IDX_DEPTH);
  // entries 5..7 do not exist, reads give zero
  wire [ADDR_W-1:0]  top_word = rd_valid ?
                                return_addr_stack[idx_lo] : '0;
  wire               at_top   = (instr_addr_counter_reg == TOP);
  wire [ADDR_W-1:0]  addr_inc = at_top ? '0 :
                                instr_addr_counter_reg + 1'b1;
  wire [ADDR_W-1:0]  top_inc  = (top_word == TOP) ? '0 : top_word + 1'b1;
  wire [ADDR_W-1:0]  imm_tgt  = ADDR_W'(branch_target[CALL_IMM_W-1:0]);
  wire               running  = ctrl_reg[CTRL_RUN_BIT];

  // word pushed this cycle: return point or address_reg
  wire [ADDR_W-1:0]  push_word = seq_ev.push_ar ? address_reg :
                                 seq_ev.irq_acc ? instr_addr_counter_reg :
                                 addr_inc;

  // next instruction address, one event per cycle
  always_comb begin
    instr_addr_counter_next = instr_addr_counter_reg;
    if (seq_ev.call_imm) begin
      instr_addr_counter_next = imm_tgt;
    end else if (seq_ev.call_ar || seq_ev.jump_ar || seq_ev.tbl_first) begin
      instr_addr_counter_next = address_reg;
    end else if (seq_ev.jump_dir) begin
      instr_addr_counter_next = branch_target;
    end else if (seq_ev.irq_acc) begin
      instr_addr_counter_next = irq_vector;
    end else if (seq_ev.ret || seq_ev.irq_ret || seq_ev.tbl_second) begin
      instr_addr_counter_next = top_word;
    end else if (seq_ev.ret_skip) begin
      instr_addr_counter_next = top_inc;
    end else if ((seq_ev.step && running) || seq_ev.push_ar || seq_ev.pop_ar) begin
      instr_addr_counter_next = addr_inc;
    end
  end

  // stack index and free context count
  always_comb begin
    stack_index_next = stack_index_reg;
    ics_free_next    = ics_free_reg;
    if (any_push) begin
      stack_index_next = {1'b0, idx_dec};
    end else if (any_pop) begin
      stack_index_next = {1'b0, idx_inc};
    end
    // free count saturates; the oldest context is simply lost
    if (seq_ev.irq_acc && ics_free_reg != 2'h0) begin
      ics_free_next = ics_free_reg - 2'h1;
    end else if (seq_ev.irq_ret && ics_free_reg != ICS_FREE_RST) begin
      ics_free_next = ics_free_reg + 2'h1;
    end
  end

  // table read sequencing
  always_comb begin
    case (tbl_reg)
      TBL_IDLE: tbl_next = seq_ev.tbl_first ? TBL_WAIT : TBL_IDLE;
      TBL_WAIT: tbl_next = seq_ev.tbl_second ? TBL_IDLE : TBL_WAIT;
      default:  tbl_next = TBL_IDLE;
    endcase
  end

  // event detection
  assign evt_set[EVT_OVF]    = any_push && (idx_dec >= IDX_HANG);
  assign evt_set[EVT_UDF]    = any_pop && !rd_valid;
  assign evt_set[EVT_DROP]   = seq_ev.irq_acc && (ics_free_reg == 2'h0);
  assign evt_set[EVT_TBLERR] = seq_ev.tbl_second && (tbl_reg != TBL_WAIT);

  // core registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      instr_addr_counter_reg <= ADDR_RESET[ADDR_W-1:0];
      stack_index_reg        <= IDX_RESET;
      ics_free_reg           <= ICS_FREE_RST;
      tbl_reg                <= TBL_IDLE;
    end else begin
      instr_addr_counter_reg <= instr_addr_counter_next;
      stack_index_reg        <= stack_index_next;
      ics_free_reg           <= ics_free_next;
      tbl_reg                <= tbl_next;
    end
  end

  // return entries, no reset: contents undefined until pushed
  for (genvar i = 0; i < RAS_DEPTH; i++) begin : g_ras
    always_ff @(posedge sys_clk) begin
      if (any_push && idx_dec == 3'(i)) begin
        return_addr_stack[i] <= push_word;
      end
    end
  end

  // context stack shifts: newest at entry 0
  for (genvar j = 0; j < ICS_DEPTH; j++) begin : g_ics
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        irq_context_stack[j] <= '0;
      end else if (seq_ev.irq_acc) begin
        irq_context_stack[j] <= (j == 0) ? status_ctx_in :
                                irq_context_stack[(j == 0) ? 0 : j - 1];
      end else if (seq_ev.irq_ret) begin
        irq_context_stack[j] <= (j == ICS_DEPTH - 1) ? '0 :
                                irq_context_stack[(j == ICS_DEPTH - 1) ? j : j + 1];
      end
    end
  end

  // pop outputs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      address_pop_reg <= '0;
      ctx_out_reg     <= '0;
      ctx_restore_reg <= 1'b0;
    end else begin
      ctx_restore_reg <= seq_ev.irq_ret;
      if (seq_ev.pop_ar) begin
        address_pop_reg <= top_word;
      end
      if (seq_ev.irq_ret) begin
        ctx_out_reg <= irq_context_stack[0];
      end
    end
  end

  // pin feedback, two stages before use
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= hangup_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // apb decode; zero wait states keep the master simple
  wire        acc_phase = psel && penable;
  wire        wr_en     = acc_phase && pwrite;
  wire        hit_ctrl  = (paddr == OFS_CTRL);
  wire        hit_state = (paddr == OFS_STATE);
  wire        hit_addr  = (paddr == OFS_ADDR);
  wire        hit_stat  = (paddr == OFS_EVT_STAT);
  wire        hit_clr   = (paddr == OFS_EVT_CLR);
  wire        hit_en    = (paddr == OFS_EVT_EN);
  wire        mapped    = hit_ctrl | hit_state | hit_addr |
                          hit_stat | hit_clr | hit_en;
  wire [EVT_W-1:0] clr_mask = (wr_en && hit_clr) ? pwdata[EVT_W-1:0] : '0;
  wire [31:0] state_word = 32'(stack_index_reg) << ST_IDX_LSB |
                           32'(ics_free_reg) << ST_FREE_LSB |
                           32'(hang) << ST_HANG_BIT |
                           32'(pin_sync_reg) << ST_PIN_BIT;
  // clear register is write-only and reads zero
  wire [31:0] rd_mux = hit_ctrl  ? 32'(ctrl_reg) :
                       hit_state ? state_word :
                       hit_addr  ? 32'(instr_addr_counter_reg) :
                       hit_stat  ? 32'(evt_stat_reg) :
                       hit_en    ? 32'(evt_en_reg) : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = acc_phase && !mapped;

  // software registers; a set in the clear cycle wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg     <= CTRL_RESET;
      evt_en_reg   <= EVT_RESET;
      evt_stat_reg <= EVT_RESET;
      prdata       <= 32'h0000_0000;
    end else begin
      evt_stat_reg <= (evt_stat_reg & ~clr_mask) | evt_set;
      if (wr_en && hit_ctrl) begin
        ctrl_reg <= pwdata[0:0];
      end
      if (wr_en && hit_en) begin
        evt_en_reg <= pwdata[EVT_W-1:0];
      end
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // outputs
  assign irq            = |(evt_stat_reg & evt_en_reg);
  assign instr_addr     = instr_addr_counter_reg;
  assign address_pop    = address_pop_reg;
  assign status_ctx_out = ctx_out_reg;
  assign ctx_restore    = ctx_restore_reg;
  // open drain: value always low, enable decides
  assign hangup_out_n   = 1'b0;
  assign hangup_oe_n    = !hang;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  AST_ADDR_RESET: assert property ($fell(srst) |-> instr_addr == '0 && stack_index_reg == IDX_RESET)
    else $error("reset state wrong");
  AST_HANG: assert property (hangup_oe_n == (stack_index_reg[2:0] < 3'h6))
    else $error("hang-up enable wrong");
  AST_IDX_TOP: assert property (stack_index_reg[3] == 1'b0)
    else $error("index top bit set");
  AST_CALL_RANGE: assert property (seq_ev.call_imm |=> instr_addr <= ADDR_W'(32'h7FF))
    else $error("immediate call out of range");
  AST_PUSH_DEC: assert property (any_push && !seq_ev.irq_acc |=>
      stack_index_reg[2:0] == $past(stack_index_reg[2:0]) - 3'h1 && $stable(ics_free_reg))
    else $error("push index step wrong");
  AST_POP_INC: assert property (any_pop && !seq_ev.irq_ret |=>
      stack_index_reg[2:0] == $past(stack_index_reg[2:0]) + 3'h1 && $stable(ics_free_reg))
    else $error("pop index step wrong");
  AST_IRQ_DEC: assert property (seq_ev.irq_acc && ics_free_reg != 2'h0 |=>
      ics_free_reg == $past(ics_free_reg) - 2'h1)
    else $error("accept free count wrong");
  AST_IRQ_INC: assert property (seq_ev.irq_ret && ics_free_reg != ICS_FREE_RST |=>
      ics_free_reg == $past(ics_free_reg) + 2'h1)
    else $error("return free count wrong");

  // pairs of events with one idle cycle between, as the sequencer spaces them
  AST_PUSH_AR: assert property (seq_ev.push_ar ##1 (!any_push && !any_pop) ##1 seq_ev.pop_ar |=>
      address_pop == $past(address_reg, 3))
    else $error("pushed word not returned");
  AST_CTX_RET: assert property (seq_ev.irq_acc ##1 (!any_push && !any_pop) ##1 seq_ev.irq_ret |=>
      ctx_restore && status_ctx_out == $past(status_ctx_in, 3))
    else $error("context not restored");
  AST_CALL_RET: assert property (seq_ev.call_ar ##1 (!any_push && !any_pop) ##1 seq_ev.ret |=>
      instr_addr == $past(addr_inc, 3))
    else $error("return address wrong");

  // target selection; the immediate field is cut to 11 bits on purpose
  AST_IMM_TGT: assert property (seq_ev.call_imm |=>
      instr_addr == ADDR_W'($past(branch_target[CALL_IMM_W-1:0])))
    else $error("immediate call target wrong");
  AST_JUMP_FULL: assert property (seq_ev.jump_dir |=>
      instr_addr == $past(branch_target))
    else $error("direct branch target wrong");
  AST_AR_TARGET: assert property (seq_ev.call_ar || seq_ev.jump_ar || seq_ev.tbl_first |=>
      instr_addr == $past(address_reg))
    else $error("register target wrong");
  AST_HALT_HOLD: assert property (seq_ev.step && !running |=>
      $stable(instr_addr))
    else $error("halted counter moved");

  // context stack: newest on top, oldest pushed out at the far end
  AST_CTX_SAVE: assert property (seq_ev.irq_acc |=>
      irq_context_stack[0] == $past(status_ctx_in))
    else $error("context not saved");
  AST_CTX_SHIFT: assert property (seq_ev.irq_acc |=>
      irq_context_stack[ICS_DEPTH-1] == $past(irq_context_stack[ICS_DEPTH-2]))
    else $error("context stack not shifted");

  // stack faults must leave a sticky trace for software
  AST_OVF_EVT: assert property (any_push && idx_lo == 3'h0 |=>
      evt_stat_reg[EVT_OVF])
    else $error("overflow event missing");
  AST_EMPTY_POP: assert property (any_pop && !rd_valid |=>
      evt_stat_reg[EVT_UDF])
    else $error("underflow event missing");

  COV_OVF: cover property (any_push && idx_lo == 3'h0);
  COV_DROP: cover property (evt_set[EVT_DROP]);
  COV_TBL: cover property (seq_ev.tbl_first ##1 seq_ev.tbl_second);
  COV_IRQ: cover property ($rose(irq));
  COV_CALL_RET: cover property (seq_ev.call_ar ##2 seq_ev.ret);

endmodule
`default_nettype wire

// File: tb/seq_model.sv
// Purpose: instruction sequencer stand-in that raises one event per cycle
// Assumes: bench picks the event code and operands
// Notes:   one-hot by construction, so two events never overlap
`timescale 1ns/10ps
`default_nettype none
module seq_model
  import pcstk_pkg::*;
(
  input  wire logic       go,     // event this cycle
  input  wire logic [3:0] sel,    // bit position in seq_ev_t
  output var  seq_ev_t    seq_ev  // event pulse to the core
);
  // idle cycles carry no event at all, never a stale one
  always_comb begin
    seq_ev = go ? seq_ev_t'(13'h0001 << sel) : seq_ev_t'(13'h0000);
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench for the program counter and return stack
// Assumes: apb slave answers at once, sequencer model drives events
// Notes:   13-bit variant so the immediate call limit is visible
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pcstk_pkg::*;
  localparam int AW = 13;
  localparam int CW = 6;
  localparam logic [3:0] E_IRET = 4'h0, E_IACC = 4'h1, E_RSK = 4'h2, E_RET = 4'h3, E_POP = 4'h4;
  localparam logic [3:0] E_PUSH = 4'h5, E_TB2 = 4'h6, E_TB1 = 4'h7, E_JAR = 4'h8, E_JDIR = 4'h9;
  localparam logic [3:0] E_CAR = 4'hA, E_CIMM = 4'hB, E_STEP = 4'hC;
  logic          sys_clk;
  logic          srst;
  logic [7:0]    paddr;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          irq;
  seq_ev_t       seq_ev;
  logic          ev_go;
  logic [3:0]    ev_sel;
  logic [AW-1:0] opnd;
  logic [AW-1:0] instr_addr;
  logic [AW-1:0] address_pop;
  logic [CW-1:0] status_ctx_out;
  logic          ctx_restore;
  logic          hangup_out_n;
  logic          hangup_oe_n;
  wire           hangup_pin;
  int            err_count;
  int            n_checks;
  logic [31:0]   rd;
  logic          er;
  logic          restore_seen;

  // open-drain pin with pull-up; released means high
  assign hangup_pin = (hangup_oe_n === 1'b0) ? hangup_out_n : 1'b1;

  seq_model u_seq (.go(ev_go), .sel(ev_sel), .seq_ev(seq_ev));

  pcstk_core #(.ADDR_W(AW), .ROM_TOP(32'h1FFF), .CTX_W(CW)) u_dut (
    .sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .seq_ev(seq_ev), .branch_target(opnd), .irq_vector(opnd), .address_reg(opnd),
    .status_ctx_in(opnd[CW-1:0]), .instr_addr(instr_addr), .address_pop(address_pop),
    .status_ctx_out(status_ctx_out), .ctx_restore(ctx_restore), .hangup_in(hangup_pin),
    .hangup_out_n(hangup_out_n), .hangup_oe_n(hangup_oe_n));

  // free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      chk("pready wait", 32'h0, 32'h1);
      complete_run();
    end
    #1;
  endtask

  // one sequencer event with one operand for target, vector, register and context
  task automatic ev(input logic [3:0] s, input logic [AW-1:0] t);
    @(posedge sys_clk);
    ev_go  <= 1'b1;
    ev_sel <= s;
    opnd   <= t;
    @(posedge sys_clk);
    ev_go <= 1'b0;
    #1;
    restore_seen = ctx_restore;
  endtask

  task automatic chk_st(input logic [3:0] idx, input logic [1:0] free);
    apb(1'b0, OFS_STATE, 32'h0);
    chk("stack index", 32'(rd[3:0]), 32'(idx));
    chk("free ctx", 32'(rd[5:4]), 32'(free));
  endtask

  task automatic t_reset;
    chk("instr_addr", 32'(instr_addr), 32'(ADDR_RESET));
    chk("hangup_oe_n", 32'(hangup_oe_n), 32'h1);
    chk("od value", 32'(hangup_out_n), 32'h0);
    chk_st(IDX_RESET, ICS_FREE_RST);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'(er), 32'h1);
    apb(1'b1, OFS_STATE, 32'h0);
    chk_st(IDX_RESET, ICS_FREE_RST);
    $display("done reset");
  endtask

  task automatic t_flow;
    ev(E_STEP, 13'h0000);
    chk("step", 32'(instr_addr), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl run", rd, 32'h0);
    ev(E_STEP, 13'h0000);
    chk("halted step", 32'(instr_addr), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1);
    ev(E_JDIR, 13'h1ABC);
    chk("direct branch", 32'(instr_addr), 32'h1ABC);
    ev(E_CIMM, 13'h1234);
    chk("imm call", 32'(instr_addr), 32'h0234);
    ev(E_CAR, 13'h1F00);
    chk("reg call", 32'(instr_addr), 32'h1F00);
    chk_st(4'h3, 2'h3);
    ev(E_RSK, 13'h0000);
    chk("return skip", 32'(instr_addr), 32'h0236);
    ev(E_RET, 13'h0000);
    chk("return", 32'(instr_addr), 32'h1ABD);
    chk_st(4'h5, 2'h3);
    ev(E_JAR, 13'h1800);
    chk("reg branch", 32'(instr_addr), 32'h1800);
    apb(1'b0, OFS_ADDR, 32'h0);
    chk("addr reg", rd, 32'h1800);
    chk("mapped ok", 32'(er), 32'h0);
    $display("done flow");
  endtask

  task automatic t_table;
    ev(E_JDIR, 13'h1FFF);
    ev(E_TB1, 13'h0100);
    chk("table first", 32'(instr_addr), 32'h0100);
    chk_st(4'h4, 2'h3);
    ev(E_TB2, 13'h0000);
    chk("table back", 32'(instr_addr), 32'h0000);
    ev(E_PUSH, 13'h1555);
    ev(E_PUSH, 13'h0AAA);
    chk_st(4'h3, 2'h3);
    ev(E_POP, 13'h0000);
    chk("pop 1", 32'(address_pop), 32'h0AAA);
    ev(E_POP, 13'h0000);
    chk("pop 2", 32'(address_pop), 32'h1555);
    chk_st(4'h5, 2'h3);
    ev(E_CAR, 13'h1000);
    ev(E_RET, 13'h0000);
    chk("call ret", 32'(instr_addr), 32'h0005);
    $display("done table");
  endtask

  task automatic t_overflow;
    for (int i = 0; i < 5; i++) begin
      ev(E_PUSH, 13'(i));
      chk("no hang", 32'(hangup_oe_n), 32'h1);
    end
    ev(E_PUSH, 13'h0005);
    chk("hang drive", 32'(hangup_oe_n), 32'h1 ^ 32'h1);
    chk_st(4'h7, 2'h3);
    apb(1'b0, OFS_STATE, 32'h0);
    chk("hang flag", 32'(rd[ST_HANG_BIT]), 32'h1);
    chk("pin low", 32'(rd[ST_PIN_BIT]), 32'h0);
    apb(1'b0, OFS_EVT_STAT, 32'h0);
    chk("ovf event", 32'(rd[EVT_OVF]), 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, OFS_EVT_EN, 32'h1);
    chk("irq on", 32'(irq), 32'h1);
    apb(1'b0, OFS_EVT_EN, 32'h0);
    chk("en readback", rd, 32'h1);
    apb(1'b1, OFS_EVT_CLR, 32'h1);
    chk("irq cleared", 32'(irq), 32'h0);
    apb(1'b0, OFS_EVT_CLR, 32'h0);
    chk("clr reads zero", rd, 32'h0);
    // the pin is meant to pull reset, so reset restores a clean stack
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("hang released", 32'(hangup_oe_n), 32'h1);
    chk_st(IDX_RESET, ICS_FREE_RST);
    // a stray second table cycle pops the empty stack
    ev(E_TB2, 13'h0000);
    chk("stray pop hang", 32'(hangup_oe_n), 32'h0);
    ev(E_PUSH, 13'h0000);
    apb(1'b0, OFS_EVT_STAT, 32'h0);
    chk("udf tblerr", rd, 32'(1 << EVT_UDF | 1 << EVT_TBLERR));
    apb(1'b1, OFS_EVT_CLR, 32'hF);
    chk_st(IDX_RESET, ICS_FREE_RST);
    $display("done overflow");
  endtask

  task automatic t_irq;
    ev(E_JDIR, 13'h0400);
    for (int i = 1; i <= 4; i++) begin
      ev(E_IACC, 13'(32'h10 + i));
      chk("vector", 32'(instr_addr), 32'h10 + i);
      chk_st(4'(5 - i), 2'((i > 3) ? 0 : 3 - i));
    end
    apb(1'b0, OFS_EVT_STAT, 32'h0);
    chk("drop event", 32'(rd[EVT_DROP]), 32'h1);
    for (int k = 0; k < 3; k++) begin
      ev(E_IRET, 13'h0000);
      chk("restore pulse", 32'(restore_seen), 32'h1);
      chk("ctx", 32'(status_ctx_out), 32'h14 - k);
      chk("resume", 32'(instr_addr), 32'h13 - k);
      chk_st(4'(2 + k), 2'(1 + k));
    end
    ev(E_RET, 13'h0000);
    chk("outer resume", 32'(instr_addr), 32'h0400);
    ev(E_IACC, 13'h0025);
    ev(E_IRET, 13'h0000);
    chk("quick ctx", 32'(status_ctx_out), 32'h25);
    chk("quick resume", 32'(instr_addr), 32'h0400);
    chk_st(IDX_RESET, ICS_FREE_RST);
    $display("done irq");
  endtask

  // reset held four cycles, then the scenarios in turn
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev_go = 1'b0;
    ev_sel = 4'h0;
    opnd = 13'h0000;
    err_count = 0;
    n_checks = 0;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_flow();
    t_table();
    t_overflow();
    t_irq();
    complete_run();
  end
endmodule
`default_nettype wire
